// File: src/memdec_pkg.sv
// Constants and types shared by the memory-space decoder and its flash map.
// Assumes one core clock; all offsets are byte addresses in their own space.
package memdec_pkg;

	// Program space
	localparam int          PROG_SPACE_BYTES = 65536;
	localparam logic [15:0] FLASH16_TOP      = 16'h3fff;
	localparam logic [15:0] FLASH8_TOP       = 16'h1fff;
	localparam logic [15:0] LOCK16_ADDR      = 16'h3bff;
	localparam logic [15:0] LOCK8_ADDR       = 16'h1fff;

	// Internal data space
	localparam logic [7:0]  LOWER_TOP        = 8'h7f;
	localparam logic [7:0]  BIT_AREA_BASE    = 8'h20;
	localparam logic [7:0]  SFR_BIT_MASK     = 8'hf8;
	localparam int          BANK_BIT0_POS    = 3;
	localparam int          BANK_BIT1_POS    = 4;

	// Register locations in the direct space above the lower half
	localparam logic [7:0]  STACK_PTR_ADDR   = 8'h81;
	localparam logic [7:0]  DATA_POINTER_LOW_ADDR    = 8'h82;
	localparam logic [7:0]  DATA_POINTER_HIGH_ADDR   = 8'h83;
	localparam logic [7:0]  PAGE_SEL_ADDR    = 8'haa;

	// Values after reset
	localparam logic [7:0]  STACK_PTR_RESET  = 8'h07;
	localparam logic [7:0]  PAGE_SEL_RESET   = 8'h00;
	localparam logic [7:0]  DATA_POINTER_BYTE_RESET  = 8'h00;

	// On-chip external RAM
	localparam int          ONCHIP_EXTERNAL_RAM_BYTES       = 1024;
	localparam int          ONCHIP_EXTERNAL_RAM_AW          = 10;

	typedef enum logic [1:0] {
		MODE_DIRECT   = 2'h0,
		MODE_INDIRECT = 2'h1,
		MODE_REGISTER = 2'h2,
		MODE_BIT      = 2'h3
	} data_mode_t;

	typedef enum logic [3:0] {
		TGT_NONE  = 4'h1,
		TGT_LOWER = 4'h2,
		TGT_UPPER = 4'h4,
		TGT_SFR   = 4'h8
	} target_t;

endpackage

// File: src/flash_map.sv
// Registered decode of one program-space address onto the flash array.
// Assumes the requester holds at most one code access per cycle.
`timescale 1ns/1ps
module flash_map #(
	parameter int FLASH_KB = 16
) (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_req,
	input  wire logic [15:0] i_addr,
	output logic             o_valid,
	output logic             o_flash,
	output logic             o_lock,
	output logic             o_reserved,
	output logic             o_outside
);
	import memdec_pkg::*;

	initial begin
		if (FLASH_KB != 16 && FLASH_KB != 8)
			$error("flash_map: FLASH_KB must be 16 or 8");
	end

	localparam logic [15:0] TOP  = (FLASH_KB == 16) ? FLASH16_TOP : FLASH8_TOP;
	localparam logic [15:0] LOCK = (FLASH_KB == 16) ? LOCK16_ADDR : LOCK8_ADDR;

	typedef struct packed {
		logic valid;
		logic flash;
		logic lock;
		logic reserved;
		logic outside;
	} fm_state_t;

	fm_state_t s_q;
	fm_state_t s_d;

	always_comb begin
		s_d = '0;
		s_d.valid = i_req;
		if (i_req) begin
			s_d.outside  = (i_addr > TOP);
			s_d.lock     = (i_addr == LOCK);
			s_d.reserved = (i_addr > LOCK) && (i_addr <= TOP);
			s_d.flash    = (i_addr < LOCK);
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_valid    = s_q.valid;
	assign o_flash    = s_q.flash;
	assign o_lock     = s_q.lock;
	assign o_reserved = s_q.reserved;
	assign o_outside  = s_q.outside;

	lock_byte_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_req && i_addr == LOCK |=> o_lock && !o_flash && !o_reserved)
		else $error("lock byte not flagged");
	reserved_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_req && i_addr > LOCK && i_addr <= TOP |=> o_reserved && !o_flash)
		else $error("reserved area taken as storage");
	flash_span_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_req |=> o_valid && (o_outside == ($past(i_addr) > TOP)))
		else $error("flash span wrong");
	cover_lock_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_valid && o_lock);

endmodule

// File: src/mem_decoder.sv
// Memory-space decoder of the core: code, internal data, stack, data pointer
// and on-chip external RAM addressing. Assumes the execution unit issues
// requests synchronous to i_clk and supplies index register contents.
`timescale 1ns/1ps
module mem_decoder #(
	parameter int FLASH_KB = 16
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_sys_rst,
	input  wire logic                   i_code_req,
	input  wire logic [15:0]            i_code_addr,
	input  wire logic                   i_data_req,
	input  wire memdec_pkg::data_mode_t i_data_mode,
	input  wire logic [7:0]             i_data_addr,
	input  wire logic [2:0]             i_reg_num,
	input  wire logic                   i_index_sel,
	input  wire logic [7:0]             i_index_value,
	input  wire logic                   i_data_wr,
	input  wire logic [7:0]             i_data_wdata,
	input  wire logic [7:0]             i_program_status_word,
	input  wire logic                   i_push,
	input  wire logic                   i_pop,
	input  wire logic                   i_data_pointer_load,
	input  wire logic [15:0]            i_data_pointer_value,
	input  wire logic                   i_xmove_req,
	input  wire logic                   i_xmove_wr,
	input  wire logic                   i_xmove_wide,
	input  wire logic                   i_xmove_flash_wr_en,
	output logic                        o_code_valid,
	output logic                        o_code_flash,
	output logic                        o_code_lock,
	output logic                        o_code_reserved,
	output logic                        o_code_outside,
	output logic                        o_data_valid,
	output memdec_pkg::target_t         o_data_target,
	output logic [7:0]                  o_data_addr,
	output logic                        o_data_is_bit,
	output logic [2:0]                  o_data_bit_pos,
	output logic                        o_data_we,
	output logic                        o_sfr_rvalid,
	output logic [7:0]                  o_sfr_rdata,
	output logic [4:0]                  o_index_loc,
	output logic                        o_stack_valid,
	output logic                        o_stack_we,
	output logic [7:0]                  o_stack_addr,
	output logic [7:0]                  o_stack_pointer,
	output logic [15:0]                 o_data_pointer,
	output logic [7:0]                  o_page_select,
	output logic                        o_onchip_external_ram_valid,
	output logic                        o_onchip_external_ram_we,
	output logic [9:0]                  o_onchip_external_ram_addr,
	output logic                        o_flash_wr_valid,
	output logic [15:0]                 o_flash_wr_addr
);
	import memdec_pkg::*;

	initial begin
		if (ONCHIP_EXTERNAL_RAM_AW != 10 || ONCHIP_EXTERNAL_RAM_BYTES != (1 << ONCHIP_EXTERNAL_RAM_AW))
			$error("mem_decoder: external RAM must be 1 kB");
		if (PROG_SPACE_BYTES != 65536)
			$error("mem_decoder: program space must be 64 kB");
	end

	typedef struct packed {
		logic [7:0]  sp;
		logic [7:0]  data_pointer_high;
		logic [7:0]  data_pointer_low;
		logic [7:0]  page;
		logic        data_valid;
		target_t     tgt;
		logic [7:0]  data_addr;
		logic        is_bit;
		logic [2:0]  bit_pos;
		logic        data_we;
		logic        sfr_rvalid;
		logic [7:0]  sfr_rdata;
		logic [4:0]  index_loc;
		logic        stack_valid;
		logic        stack_we;
		logic [7:0]  stack_addr;
		logic        onchip_external_ram_valid;
		logic        onchip_external_ram_we;
		logic [9:0]  onchip_external_ram_addr;
		logic        fwr_valid;
		logic [15:0] fwr_addr;
	} dec_state_t;

	localparam dec_state_t RESET_STATE = '{
		sp:        STACK_PTR_RESET,
		data_pointer_high:       DATA_POINTER_BYTE_RESET,
		data_pointer_low:       DATA_POINTER_BYTE_RESET,
		page:      PAGE_SEL_RESET,
		tgt:       TGT_NONE,
		default:   '0
	};

	dec_state_t s_q;
	dec_state_t s_d;

	logic [1:0]  bank;
	logic [15:0] xaddr;
	logic        sfr_write;

	// Register banks are chosen by the two bank-select bits of the status word
	assign bank = {i_program_status_word[BANK_BIT1_POS],
	               i_program_status_word[BANK_BIT0_POS]};

	// Narrow form borrows the page as high byte; wide form takes the pointer
	assign xaddr = i_xmove_wide ? {s_q.data_pointer_high, s_q.data_pointer_low}
	                            : {s_q.page, i_index_value};

	assign sfr_write = i_data_req && i_data_wr && i_data_mode == MODE_DIRECT
	                   && i_data_addr > LOWER_TOP;

	always_comb begin
		s_d = s_q;
		s_d.data_valid  = i_data_req;
		s_d.data_we     = i_data_req && i_data_wr;
		s_d.sfr_rvalid  = 1'b0;
		s_d.stack_valid = 1'b0;
		s_d.stack_we    = 1'b0;
		s_d.onchip_external_ram_valid  = 1'b0;
		s_d.onchip_external_ram_we     = 1'b0;
		s_d.fwr_valid   = 1'b0;
		s_d.index_loc   = {bank, 2'b00, i_index_sel};

		if (i_data_req) begin
			s_d.is_bit  = 1'b0;
			s_d.bit_pos = 3'h0;
			case (i_data_mode)
			MODE_DIRECT: begin
				s_d.data_addr = i_data_addr;
				s_d.tgt = (i_data_addr > LOWER_TOP) ? TGT_SFR
				                                    : TGT_LOWER;
			end
			MODE_INDIRECT: begin
				s_d.data_addr = i_index_value;
				s_d.tgt = (i_index_value > LOWER_TOP) ? TGT_UPPER
				                                      : TGT_LOWER;
			end
			MODE_REGISTER: begin
				s_d.data_addr = {3'h0, bank, i_reg_num};
				s_d.tgt = TGT_LOWER;
			end
			MODE_BIT: begin
				// Operand class alone makes this a bit access
				s_d.is_bit  = 1'b1;
				s_d.bit_pos = i_data_addr[2:0];
				if (i_data_addr > LOWER_TOP) begin
					s_d.data_addr = i_data_addr & SFR_BIT_MASK;
					s_d.tgt = TGT_SFR;
				end else begin
					s_d.data_addr = BIT_AREA_BASE
					                + {4'h0, i_data_addr[6:3]};
					s_d.tgt = TGT_LOWER;
				end
			end
			default: begin
				s_d.data_addr = i_data_addr;
				s_d.tgt = TGT_NONE;
			end
			endcase
		end

		// Own register reads answer one cycle later with pre-write contents
		if (i_data_req && !i_data_wr && i_data_mode == MODE_DIRECT) begin
			case (i_data_addr)
			STACK_PTR_ADDR: begin
				s_d.sfr_rvalid = 1'b1;
				s_d.sfr_rdata  = s_q.sp;
			end
			DATA_POINTER_LOW_ADDR: begin
				s_d.sfr_rvalid = 1'b1;
				s_d.sfr_rdata  = s_q.data_pointer_low;
			end
			DATA_POINTER_HIGH_ADDR: begin
				s_d.sfr_rvalid = 1'b1;
				s_d.sfr_rdata  = s_q.data_pointer_high;
			end
			PAGE_SEL_ADDR: begin
				s_d.sfr_rvalid = 1'b1;
				s_d.sfr_rdata  = s_q.page;
			end
			default: s_d.sfr_rvalid = 1'b0;
			endcase
		end

		if (sfr_write) begin
			case (i_data_addr)
			STACK_PTR_ADDR: s_d.sp   = i_data_wdata;
			DATA_POINTER_LOW_ADDR:  s_d.data_pointer_low  = i_data_wdata;
			DATA_POINTER_HIGH_ADDR: s_d.data_pointer_high  = i_data_wdata;
			PAGE_SEL_ADDR:  s_d.page = i_data_wdata;
			default:        s_d.page = s_q.page;
			endcase
		end

		// A whole-pointer load wins over a byte write in the same cycle
		if (i_data_pointer_load) begin
			s_d.data_pointer_high = i_data_pointer_value[15:8];
			s_d.data_pointer_low = i_data_pointer_value[7:0];
		end

		// Stack wraps at 8 bits, so any start and any depth up to 256 works
		if (i_push) begin
			s_d.stack_valid = 1'b1;
			s_d.stack_we    = 1'b1;
			s_d.stack_addr  = s_q.sp + 8'h01;
			s_d.sp          = s_q.sp + 8'h01;
		end else if (i_pop) begin
			s_d.stack_valid = 1'b1;
			s_d.stack_addr  = s_q.sp;
			s_d.sp          = s_q.sp - 8'h01;
		end

		if (i_xmove_req) begin
			if (i_xmove_wr && i_xmove_flash_wr_en) begin
				s_d.fwr_valid = 1'b1;
				s_d.fwr_addr  = xaddr;
			end else begin
				s_d.onchip_external_ram_valid = 1'b1;
				s_d.onchip_external_ram_we    = i_xmove_wr;
				s_d.onchip_external_ram_addr  = xaddr[ONCHIP_EXTERNAL_RAM_AW-1:0];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			s_q <= RESET_STATE;
		else
			s_q <= s_d;
	end

	flash_map #(
		.FLASH_KB (FLASH_KB)
	) u_flash_map (
		.i_clk      (i_clk),
		.i_sys_rst  (i_sys_rst),
		.i_req      (i_code_req),
		.i_addr     (i_code_addr),
		.o_valid    (o_code_valid),
		.o_flash    (o_code_flash),
		.o_lock     (o_code_lock),
		.o_reserved (o_code_reserved),
		.o_outside  (o_code_outside)
	);

	assign o_data_valid     = s_q.data_valid;
	assign o_data_target    = s_q.tgt;
	assign o_data_addr      = s_q.data_addr;
	assign o_data_is_bit    = s_q.is_bit;
	assign o_data_bit_pos   = s_q.bit_pos;
	assign o_data_we        = s_q.data_we;
	assign o_sfr_rvalid     = s_q.sfr_rvalid;
	assign o_sfr_rdata      = s_q.sfr_rdata;
	assign o_index_loc      = s_q.index_loc;
	assign o_stack_valid    = s_q.stack_valid;
	assign o_stack_we       = s_q.stack_we;
	assign o_stack_addr     = s_q.stack_addr;
	assign o_stack_pointer  = s_q.sp;
	assign o_data_pointer   = {s_q.data_pointer_high, s_q.data_pointer_low};
	assign o_page_select    = s_q.page;
	assign o_onchip_external_ram_valid     = s_q.onchip_external_ram_valid;
	assign o_onchip_external_ram_we        = s_q.onchip_external_ram_we;
	assign o_onchip_external_ram_addr      = s_q.onchip_external_ram_addr;
	assign o_flash_wr_valid = s_q.fwr_valid;
	assign o_flash_wr_addr  = s_q.fwr_addr;

	push_addr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_push |=> o_stack_we && o_stack_addr == $past(o_stack_pointer) + 8'h01
		        && o_stack_pointer == o_stack_addr)
		else $error("push address or pointer wrong");
	sp_reset_a: assert property (@(posedge i_clk)
		i_sys_rst |=> o_stack_pointer == STACK_PTR_RESET || i_sys_rst
		              || $past(i_push) || $past(i_pop) || $past(sfr_write))
		else $error("stack pointer not 0x07 after reset");
	direct_sfr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_data_req && i_data_mode == MODE_DIRECT && i_data_addr[7]
		|=> o_data_target == TGT_SFR && !o_data_is_bit)
		else $error("direct high access not sent to registers");
	indirect_up_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_data_req && i_data_mode == MODE_INDIRECT
		|=> o_data_addr == $past(i_index_value)
		 && (o_data_target == (o_data_addr[7] ? TGT_UPPER : TGT_LOWER)))
		else $error("indirect access misrouted");
	bank_reg_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_data_req && i_data_mode == MODE_REGISTER
		|=> o_data_addr == {3'h0, $past(i_program_status_word[4:3]),
		                    $past(i_reg_num)})
		else $error("register operand outside active bank");
	bit_addr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_data_req && i_data_mode == MODE_BIT && !i_data_addr[7]
		|=> o_data_is_bit && o_data_addr[7:4] == 4'h2
		 && {o_data_addr[3:0], o_data_bit_pos} == $past(i_data_addr[6:0]))
		else $error("bit address decode wrong");
	onchip_external_ram_wide_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_xmove_req && i_xmove_wide && !i_xmove_wr && !i_data_pointer_load
		|=> o_onchip_external_ram_valid && o_onchip_external_ram_addr == $past(o_data_pointer[9:0]))
		else $error("wide external move address wrong");
	onchip_external_ram_page_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_xmove_req && !i_xmove_wide && !i_xmove_flash_wr_en
		|=> o_onchip_external_ram_valid && o_onchip_external_ram_addr
		    == {$past(o_page_select[1:0]), $past(i_index_value)})
		else $error("paged external move address wrong");
	flash_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_xmove_req && i_xmove_wr && i_xmove_flash_wr_en
		|=> o_flash_wr_valid && !o_onchip_external_ram_valid)
		else $error("flash write mode not honoured");
	data_pointer_bytes_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_data_req && !i_data_wr && i_data_mode == MODE_DIRECT
		&& i_data_addr == DATA_POINTER_HIGH_ADDR
		|=> o_sfr_rvalid && o_sfr_rdata == $past(o_data_pointer[15:8]))
		else $error("data pointer high byte read wrong");

	cover_push_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_stack_valid && o_stack_we ##1 o_stack_valid && !o_stack_we);
	cover_upper_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_data_valid && o_data_target == TGT_UPPER);
	cover_onchip_external_ram_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_onchip_external_ram_valid && o_onchip_external_ram_we);
	cover_fwr_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_flash_wr_valid);

endmodule

// File: tb/cpu_regs_model.sv
// Execution-unit side model: the 32-byte register bank file that feeds
// the index register contents. Assumes the bench writes it between requests.
`timescale 1ns/1ps
module cpu_regs_model (
	input  wire logic       i_clk,
	input  wire logic       i_wr,
	input  wire logic [4:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	input  wire logic [7:0] i_psw,
	input  wire logic       i_sel,
	output logic [7:0]      o_value
);
	logic [7:0] regs [32];
	// Bank follows the status bits of the same cycle, as the core does
	assign o_value = regs[{i_psw[4:3], 2'b00, i_sel}];
	always_ff @(posedge i_clk) begin
		if (i_wr) begin
			regs[i_waddr] <= i_wdata;
		end
	end
endmodule

// File: tb/cpu_memory_address_decoder_bench.sv
// Self-checking bench for the memory-space decoder, 16 kB part.
// Assumes results show one cycle after the request edge.
`timescale 1ns/1ps
module cpu_memory_address_decoder_bench;
	import memdec_pkg::*;
	logic i_clk = 1'b0, i_sys_rst = 1'b1;
	logic i_code_req = 1'b0, i_data_req = 1'b0, i_index_sel = 1'b0;
	logic i_data_wr = 1'b0, i_push = 1'b0, i_pop = 1'b0, i_data_pointer_load = 1'b0;
	logic i_xmove_req = 1'b0, i_xmove_wr = 1'b0, i_xmove_wide = 1'b0;
	logic i_xmove_flash_wr_en = 1'b0, pw_en = 1'b0;
	logic [15:0] i_code_addr = 16'h0, i_data_pointer_value = 16'h0;
	logic [7:0] i_data_addr = 8'h0, i_data_wdata = 8'h0, pw_d = 8'h0;
	logic [7:0] i_program_status_word = 8'h0;
	logic [2:0] i_reg_num = 3'h0;
	logic [4:0] pw_a = 5'h0;
	data_mode_t i_data_mode = MODE_DIRECT;
	wire logic [7:0] i_index_value;
	logic o_code_valid, o_code_flash, o_code_lock, o_code_reserved;
	logic o_code_outside, o_data_valid, o_data_is_bit, o_data_we;
	logic o_sfr_rvalid, o_stack_valid, o_stack_we, o_onchip_external_ram_valid, o_onchip_external_ram_we;
	logic o_flash_wr_valid;
	target_t o_data_target;
	logic [7:0] o_data_addr, o_sfr_rdata, o_stack_addr, o_stack_pointer;
	logic [7:0] o_page_select, sp, pg, sh [32];
	logic [2:0] o_data_bit_pos;
	logic [4:0] o_index_loc;
	logic [15:0] o_data_pointer, o_flash_wr_addr, dp;
	logic [9:0] o_onchip_external_ram_addr;
	logic [35:0] q [$];
	logic [35:0] note;
	logic [31:0] r;
	int errors = 0, n_tests = 0;
	logic [15:0] ca [8] = '{16'h0000, 16'h1fff, 16'h3bfe, 16'h3bff,
		16'h3c00, 16'h3fff, 16'h4000, 16'hffff};

	mem_decoder #(.FLASH_KB(16)) uut (.*);
	cpu_regs_model partner (.i_clk(i_clk), .i_wr(pw_en), .i_waddr(pw_a),
		.i_wdata(pw_d), .i_psw(i_program_status_word),
		.i_sel(i_index_sel), .o_value(i_index_value));

	always #2 i_clk = ~i_clk;

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] obs(input logic [3:0] k);
		case (k)
		4'h0: obs = {27'h0, o_code_valid, o_code_flash, o_code_lock,
			o_code_reserved, o_code_outside};
		4'h1: obs = {14'h0, o_data_valid, o_data_we, o_data_target,
			o_data_addr, o_data_is_bit, o_data_bit_pos};
		4'h2: obs = {23'h0, o_sfr_rvalid, o_sfr_rdata};
		4'h3: obs = {14'h0, o_stack_valid, o_stack_we, o_stack_addr,
			o_stack_pointer};
		4'h4: obs = {20'h0, o_onchip_external_ram_valid, o_onchip_external_ram_we, o_onchip_external_ram_addr};
		default: obs = {15'h0, o_flash_wr_valid, o_flash_wr_addr};
		endcase
	endfunction

	// Any result pulse retires the oldest note
	always @(negedge i_clk) begin
		if (!i_sys_rst && (o_code_valid | o_data_valid | o_stack_valid |
			o_onchip_external_ram_valid | o_flash_wr_valid | o_sfr_rvalid) === 1'b1) begin
			note = (q.size() != 0) ? q.pop_front() : 36'hf_0000_0000;
			check({note[35:32], obs(note[35:32])}, note);
		end
	end

	function automatic logic [7:0] idx();
		return sh[{i_program_status_word[4:3], 2'b00, i_index_sel}];
	endfunction

	task automatic drive(input data_mode_t m, input logic [7:0] a,
		input logic [2:0] rn, input logic wr, input logic [7:0] wd);
		@(negedge i_clk);
		i_data_req = 1'b1;
		i_data_mode = m;
		i_data_addr = a;
		i_reg_num = rn;
		i_data_wr = wr;
		i_data_wdata = wd;
		@(negedge i_clk);
		i_data_req = 1'b0;
		i_data_wr = 1'b0;
	endtask

	task automatic dat(input data_mode_t m, input logic [7:0] a,
		input logic [2:0] rn, input logic wr, input logic [7:0] wd);
		logic [7:0] ea;
		logic [2:0] p;
		logic       b;
		target_t    t;
		ea = a;
		p = a[2:0];
		b = 1'b0;
		t = (a > LOWER_TOP) ? TGT_SFR : TGT_LOWER;
		if (m == MODE_INDIRECT) begin
			ea = idx();
			t = (ea > LOWER_TOP) ? TGT_UPPER : TGT_LOWER;
		end else if (m == MODE_REGISTER) begin
			ea = {3'h0, i_program_status_word[4:3], rn};
			t = TGT_LOWER;
		end else if (m == MODE_BIT) begin
			b = 1'b1;
			ea = (a > LOWER_TOP) ? (a & SFR_BIT_MASK) :
				BIT_AREA_BASE + {4'h0, a[6:3]};
		end else if (wr) begin
			if (a == STACK_PTR_ADDR) sp = wd;
			if (a == DATA_POINTER_LOW_ADDR) dp[7:0] = wd;
			if (a == DATA_POINTER_HIGH_ADDR) dp[15:8] = wd;
			if (a == PAGE_SEL_ADDR) pg = wd;
		end
		if (m != MODE_BIT) p = 3'h0;
		q.push_back({4'h1, 14'h0, 1'b1, wr, t, ea, b, p});
		drive(m, a, rn, wr, wd);
	endtask

	task automatic regrd(input logic [7:0] a, input logic [7:0] v);
		q.push_back({4'h2, 23'h0, 1'b1, v});
		drive(MODE_DIRECT, a, 3'h0, 1'b0, 8'h0);
	endtask

	task automatic pw(input logic [4:0] a, input logic [7:0] v);
		@(negedge i_clk);
		pw_en = 1'b1;
		pw_a = a;
		pw_d = v;
		sh[a] = v;
		@(negedge i_clk);
		pw_en = 1'b0;
	endtask

	task automatic xm(input logic wr, input logic wide, input logic fen);
		// A flash write takes the full 16-bit address; the RAM path keeps only its low 10 bits
		if (wr && fen) q.push_back({4'h5, 15'h0, 1'b1,
			wide ? dp : {pg, idx()}});
		else q.push_back({4'h4, 20'h0, 1'b1, wr,
			wide ? dp[9:0] : {pg[1:0], idx()}});
		@(negedge i_clk);
		i_xmove_req = 1'b1;
		i_xmove_wr = wr;
		i_xmove_wide = wide;
		i_xmove_flash_wr_en = fen;
		@(negedge i_clk);
		i_xmove_req = 1'b0;
	endtask

	task automatic dl(input logic [15:0] v);
		@(negedge i_clk);
		i_data_pointer_load = 1'b1;
		i_data_pointer_value = v;
		dp = v;
		@(negedge i_clk);
		i_data_pointer_load = 1'b0;
		check(36'(o_data_pointer), 36'(dp));
	endtask

	task automatic stk(input logic ph, input logic pp, input int n);
		@(negedge i_clk);
		i_push = ph;
		i_pop = pp;
		repeat (n) begin
			if (ph) begin
				sp = sp + 8'h1;
				q.push_back({4'h3, 14'h0, 2'b11, sp, sp});
			end else begin
				q.push_back({4'h3, 14'h0, 2'b10, sp, sp - 8'h1});
				sp = sp - 8'h1;
			end
			@(negedge i_clk);
		end
		i_push = 1'b0;
		i_pop = 1'b0;
	endtask

	task automatic do_reset();
		@(negedge i_clk);
		i_sys_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_sys_rst = 1'b0;
		sp = STACK_PTR_RESET;
		dp = 16'h0;
		pg = PAGE_SEL_RESET;
		check(36'(o_stack_pointer), 36'(STACK_PTR_RESET));
		check(36'({o_page_select, o_data_pointer}), 36'h0);
	endtask

	initial begin
		r = $urandom(99);
		repeat (16) @(posedge i_clk);
		do_reset();
		foreach (ca[i]) begin
			q.push_back({4'h0, 27'h0, 1'b1, ca[i] < LOCK16_ADDR,
				ca[i] == LOCK16_ADDR, ca[i] > LOCK16_ADDR &&
				ca[i] <= FLASH16_TOP, ca[i] > FLASH16_TOP});
			@(negedge i_clk);
			i_code_req = 1'b1;
			i_code_addr = ca[i];
			@(negedge i_clk);
			i_code_req = 1'b0;
		end
		for (int k = 0; k < 32; k++) pw(5'(k), 8'($urandom));
		pw(5'd8, 8'h7f);
		pw(5'd9, 8'h80);
		pw(5'd0, 8'h34);
		for (int k = 0; k < 8; k++) begin
			i_program_status_word = {3'h0, 2'(k), 3'h0};
			i_index_sel = k[2];
			dat(MODE_REGISTER, 8'h0, 3'(k), 1'b0, 8'h0);
			dat(MODE_INDIRECT, 8'h0, 3'h0, 1'b0, 8'h0);
			check(36'(o_index_loc), 36'({2'(k), 2'b00, k[2]}));
		end
		foreach (ca[i]) dat(MODE_BIT, ca[i][7:0] ^ 8'h13, 3'h0, 1'b1, 8'h0);
		dat(MODE_BIT, 8'h7f, 3'h0, 1'b0, 8'h0);
		dat(MODE_DIRECT, 8'h90, 3'h0, 1'b0, 8'h0);
		i_program_status_word = 8'h0;
		i_index_sel = 1'b0;
		dat(MODE_DIRECT, PAGE_SEL_ADDR, 3'h0, 1'b1, 8'h12);
		regrd(PAGE_SEL_ADDR, 8'h12);
		dat(MODE_DIRECT, DATA_POINTER_HIGH_ADDR, 3'h0, 1'b1, 8'h12);
		dat(MODE_DIRECT, DATA_POINTER_LOW_ADDR, 3'h0, 1'b1, 8'h34);
		regrd(DATA_POINTER_HIGH_ADDR, 8'h12);
		check(36'(o_data_pointer), 36'h1234);
		for (int k = 0; k < 8; k++) xm(k[0], k[1], k[2]);
		dat(MODE_DIRECT, PAGE_SEL_ADDR, 3'h0, 1'b1, 8'hff);
		xm(1'b0, 1'b0, 1'b0);
		stk(1'b1, 1'b0, 2);
		stk(1'b1, 1'b1, 1);
		stk(1'b0, 1'b1, 3);
		dat(MODE_DIRECT, STACK_PTR_ADDR, 3'h0, 1'b1, 8'hff);
		stk(1'b1, 1'b0, 1);
		stk(1'b0, 1'b1, 1);
		regrd(STACK_PTR_ADDR, sp);
		repeat (40) begin
			r = $urandom;
			i_program_status_word = r[7:0];
			i_index_sel = r[8];
			dat(data_mode_t'(r[10:9]), r[23:16], r[13:11], r[14], r[31:24]);
			if (r[15]) dl(r[31:16]);
			else xm(r[24], r[25], r[26]);
		end
		stk(1'b1, 1'b0, 1);
		do_reset();
		stk(1'b1, 1'b0, 1);
		for (int i = 0; i < 50 && q.size() != 0; i++) @(negedge i_clk);
		if (q.size() != 0) errors++;
		results();
	end
endmodule
